/* File: bench/cflb_bank_asserts.sv */
// checker for the fault latch bank: latched flags, mask bits, reserved bits
// assumes it is bound to cflb_bank and the master holds a request until pready
`timescale 1ns/1ns
module cflb_bank_asserts (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cflb_pkg::CFLB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [31:0] PRDATA,
  input wire logic PREADY,
  input wire cflb_pkg::cflb_fault_t FAULT_IN,
  input wire cflb_pkg::cflb_mask_t MASK_OUT
);
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);
  logic rd, wr;
  assign rd = PSEL && PENABLE && PREADY && !PWRITE;
  assign wr = PSEL && PENABLE && PREADY && PWRITE;
  // detector inputs held long enough to pass the synchroniser and latch
  sequence s_quiet;
    $stable(FAULT_IN)[*6];
  endsequence
  property p_lat(a, m);
    s_quiet ##0 (rd && PADDR == a) |-> (PRDATA[7:0] & m) == m;
  endproperty
  AST_IN_ONE: assert property (p_lat(10'h0D8, FAULT_IN.in_one))
    else $error("input one flag lost");
  AST_IN_TWO: assert property (p_lat(10'h0DC, FAULT_IN.in_two))
    else $error("input two flag lost");
  AST_OUT_ONE: assert property (p_lat(10'h0E0, {FAULT_IN.out_one, 4'h0}))
    else $error("output one flag lost");
  AST_OUT_TWO: assert property (p_lat(10'h0E4, {FAULT_IN.out_two, 4'h0}))
    else $error("output two flag lost");
  AST_REG_SHORT: assert property (p_lat(10'h0E4, {7'h0, FAULT_IN.regulator_short}))
    else $error("regulator short flag lost");
  AST_MASK_ONE: assert property (wr && PADDR == 10'h0E0 |=>
    {MASK_OUT.converter_one_overload_mask, MASK_OUT.converter_two_overload_mask}
    == $past(PWDATA[3:2])) else $error("converter masks not written");
  AST_MASK_TWO: assert property (wr && PADDR == 10'h0E4 |=>
    MASK_OUT.regulator_short_mask == $past(PWDATA[1])) else $error("regulator mask not written");
  AST_RSVD: assert property (rd && (PADDR == 10'h0E0 || PADDR == 10'h0E4) |->
    (PADDR[2] ? PRDATA[3:2] : PRDATA[1:0]) == 2'h0) else $error("reserved bits not zero");
endmodule
bind cflb_bank cflb_bank_asserts i_cflb_bank_asserts (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N),
  .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA),
  .PRDATA(PRDATA), .PREADY(PREADY), .FAULT_IN(FAULT_IN), .MASK_OUT(MASK_OUT));

/* File: bench/cflb_bank_tb.sv */
// bench for the fault latch bank: reset, latching, masks, interrupt, bus error
// assumes the checker is bound from its own file
`timescale 1ns/1ns
module cflb_bank_tb;
  logic SYS_CLK, ARST_N, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IRQ, e;
  logic [cflb_pkg::CFLB_ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA, q;
  cflb_pkg::cflb_fault_t FAULT_IN;
  cflb_pkg::cflb_mask_t MASK_OUT;
  int n_fail = 0, check_count = 0, cyc = 0;
  cflb_bank i_cflb_bank (.SYS_CLK(SYS_CLK), .ARST_N(ARST_N), .PSEL(PSEL), .PENABLE(PENABLE),
    .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PSTRB(4'hF), .PRDATA(PRDATA),
    .PREADY(PREADY), .PSLVERR(PSLVERR), .FAULT_IN(FAULT_IN), .MASK_OUT(MASK_OUT), .IRQ(IRQ));
  // --------------------------------------------------------------------
  // bus cycle, comparison and fault drive
  // --------------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] ex, got);
    check_count++;
    if (got !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    @(posedge SYS_CLK);
    PSEL <= 1'b1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge SYS_CLK);
    PENABLE <= 1'b1;
    do @(posedge SYS_CLK); while (PREADY !== 1'b1);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask
  // holds the new fault levels past the synchroniser and latch
  task automatic flt(input cflb_pkg::cflb_fault_t f);
    @(posedge SYS_CLK);
    FAULT_IN <= f;
    repeat (4) @(posedge SYS_CLK);
  endtask
  task automatic t_reset();
    for (int i = 0; i < 4; i++) begin
      apb(1'b0, 10'h0D8 + 10'(i * 4), 32'h0);
      chk("reset value", 32'h0, q);
    end
    chk("reset masks", 32'h0, 32'(MASK_OUT));
    $display("reset test done");
  endtask
  task automatic t_latch();
    logic [7:0] ex [4] = '{8'hA5, 8'h3C, 8'h90, 8'h61};
    flt({8'hA5, 8'h3C, 4'h9, 4'h6, 1'b1});
    for (int p = 0; p < 3; p++) begin
      if (p == 1) flt('0);
      for (int i = 0; i < 4; i++) begin
        apb(1'b0, 10'h0D8 + 10'(i * 4), 32'h0);
        chk("latched flags", (p < 2) ? 32'(ex[i]) : 32'h0, q);
      end
    end
    $display("latch test done");
  endtask
  task automatic t_mask();
    apb(1'b1, 10'h0D8, 32'hFFFF_FFFF);
    apb(1'b1, 10'h0E0, 32'hFFFF_FFFC);
    apb(1'b1, 10'h0E4, 32'hFFFF_FFF3);
    apb(1'b0, 10'h0D8, 32'h0);
    chk("read only input", 32'h0, q);
    apb(1'b0, 10'h0E0, 32'h0);
    chk("output one", 32'h0C, q);
    apb(1'b0, 10'h0E4, 32'h0);
    chk("output two", 32'h02, q);
    chk("masks set", 32'h7, 32'(MASK_OUT));
    apb(1'b1, 10'h0E0, 32'h0);
    @(posedge SYS_CLK);
    chk("masks cleared", 32'h1, 32'(MASK_OUT));
    apb(1'b0, 10'h100, 32'h0);
    chk("bus error", 32'h1, {q[31:1], e});
    $display("mask test done");
  endtask
  task automatic t_irq();
    apb(1'b1, 10'h0F8, 32'hF);
    flt(21'h0_0001);
    chk("masked fault irq", 32'h0, 32'(IRQ));
    apb(1'b0, 10'h0E4, 32'h0);
    chk("masked fault seen", 32'h03, q);
    flt(21'h0_2001);
    chk("irq raised", 32'h1, 32'(IRQ));
    for (int i = 1; i >= 0; i--) begin
      apb(1'b1, 10'h0FC, 32'(2 * i));
      repeat (2) @(posedge SYS_CLK);
      chk("irq mask", 32'(1 - i), 32'(IRQ));
    end
    flt('0);
    chk("irq sticky", 32'h1, 32'(IRQ));
    apb(1'b0, 10'h0F8, 32'h0);
    chk("irq status", 32'h2, q);
    apb(1'b1, 10'h0F8, 32'hF);
    repeat (2) @(posedge SYS_CLK);
    chk("irq cleared", 32'h0, 32'(IRQ));
    $display("irq test done");
  endtask
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial begin
    SYS_CLK = 1'b0;
    forever #20 SYS_CLK = ~SYS_CLK;
  end
  always @(posedge SYS_CLK) begin
    cyc++;
    if (cyc == 5000) begin
      n_fail++;
      close_out();
    end
  end
  initial begin
    {ARST_N, PSEL, PENABLE, PWRITE, PADDR, PWDATA, FAULT_IN} = '0;
    repeat (20) @(posedge SYS_CLK);
    ARST_N <= 1'b1;
    t_reset();
    t_latch();
    t_mask();
    t_irq();
    close_out();
  end
endmodule

/* File: hw/cflb_bank.sv */
// channel fault latch bank: four latched fault registers with mask bits on apb
// assumes fault inputs are level detector outputs from another clock domain
`timescale 1ns/1ns
module cflb_bank (
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [cflb_pkg::CFLB_ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  input wire logic [3:0] PSTRB,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire cflb_pkg::cflb_fault_t FAULT_IN,
  output cflb_pkg::cflb_mask_t MASK_OUT,
  output logic IRQ
);

  // ----------------------------------------------------------------------
  // detector synchronisers
  // ----------------------------------------------------------------------
  cflb_pkg::cflb_fault_t meta_ff;
  cflb_pkg::cflb_fault_t sync_ff;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      meta_ff <= '0;
      sync_ff <= '0;
    end else begin
      meta_ff <= FAULT_IN;
      sync_ff <= meta_ff;
    end
  end

  // ----------------------------------------------------------------------
  // bus decode
  // ----------------------------------------------------------------------
  function automatic logic hit(input logic [cflb_pkg::CFLB_ADDR_W-1:0] a,
                               input logic [7:0] idx);
    hit = (a == {idx, 2'b00});
  endfunction

  logic acc;
  logic wr;
  logic rd;
  logic mapped;
  assign acc = PSEL && PENABLE && PREADY;
  assign wr = acc && PWRITE && PSTRB[0];
  assign rd = acc && !PWRITE;
  assign mapped = hit(PADDR, cflb_pkg::CFLB_IDX_IN_ONE) || hit(PADDR, cflb_pkg::CFLB_IDX_IN_TWO)
    || hit(PADDR, cflb_pkg::CFLB_IDX_OUT_ONE) || hit(PADDR, cflb_pkg::CFLB_IDX_OUT_TWO)
    || hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_STAT) || hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_MASK);

  // ----------------------------------------------------------------------
  // fault latches
  // ----------------------------------------------------------------------
  logic [7:0] in_one_ff;
  logic [7:0] in_two_ff;
  logic [3:0] out_one_ff;
  logic [3:0] out_two_ff;
  logic reg_short_ff;
  logic rd_in_one;
  logic rd_in_two;
  logic rd_out_one;
  logic rd_out_two;
  assign rd_in_one = rd && hit(PADDR, cflb_pkg::CFLB_IDX_IN_ONE);
  assign rd_in_two = rd && hit(PADDR, cflb_pkg::CFLB_IDX_IN_TWO);
  assign rd_out_one = rd && hit(PADDR, cflb_pkg::CFLB_IDX_OUT_ONE);
  assign rd_out_two = rd && hit(PADDR, cflb_pkg::CFLB_IDX_OUT_TWO);

  // set wins over read clear; a flag stays while its fault persists
  // only the bits handed out in prdata are cleared, so a flag set during the wait state survives
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      in_one_ff <= cflb_pkg::CFLB_LATCH_RST;
      in_two_ff <= cflb_pkg::CFLB_LATCH_RST;
      out_one_ff <= '0;
      out_two_ff <= '0;
      reg_short_ff <= 1'b0;
    end else begin
      in_one_ff <= (in_one_ff & ~(rd_in_one ? PRDATA[7:0] : 8'h00)) | sync_ff.in_one;
      in_two_ff <= (in_two_ff & ~(rd_in_two ? PRDATA[7:0] : 8'h00)) | sync_ff.in_two;
      out_one_ff <= (out_one_ff & ~(rd_out_one ? PRDATA[7:4] : 4'h0)) | sync_ff.out_one;
      out_two_ff <= (out_two_ff & ~(rd_out_two ? PRDATA[7:4] : 4'h0)) | sync_ff.out_two;
      reg_short_ff <= (reg_short_ff & !(rd_out_two && PRDATA[0])) | sync_ff.regulator_short;
    end
  end

  // ----------------------------------------------------------------------
  // mask bits
  // ----------------------------------------------------------------------
  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      MASK_OUT <= '0;
    end else begin
      if (wr && hit(PADDR, cflb_pkg::CFLB_IDX_OUT_ONE)) begin
        MASK_OUT.converter_one_overload_mask <= PWDATA[cflb_pkg::CFLB_CONV_ONE_MASK_BIT];
        MASK_OUT.converter_two_overload_mask <= PWDATA[cflb_pkg::CFLB_CONV_TWO_MASK_BIT];
      end
      if (wr && hit(PADDR, cflb_pkg::CFLB_IDX_OUT_TWO)) begin
        MASK_OUT.regulator_short_mask <= PWDATA[cflb_pkg::CFLB_REG_SHORT_MASK_BIT];
      end
    end
  end

  // ----------------------------------------------------------------------
  // interrupt status and mask
  // ----------------------------------------------------------------------
  // bit0 input one, bit1 input two, bit2 output one, bit3 output two/regulator
  logic [3:0] irq_stat_ff;
  logic [3:0] irq_mask_ff;
  logic [3:0] irq_event;
  logic [3:0] irq_clr;
  assign irq_event = {(|sync_ff.out_two) | (sync_ff.regulator_short & ~MASK_OUT.regulator_short_mask),
                      |sync_ff.out_one, |sync_ff.in_two, |sync_ff.in_one};
  assign irq_clr = (wr && hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_STAT)) ? PWDATA[3:0] : 4'h0;

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_stat_ff <= cflb_pkg::CFLB_IRQ_RST;
    end else begin
      irq_stat_ff <= (irq_stat_ff & ~irq_clr) | irq_event;
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      irq_mask_ff <= cflb_pkg::CFLB_IRQ_RST;
    end else if (wr && hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_MASK)) begin
      irq_mask_ff <= PWDATA[3:0];
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      IRQ <= 1'b0;
    end else begin
      IRQ <= |(((irq_stat_ff & ~irq_clr) | irq_event) & ~irq_mask_ff);
    end
  end

  // ----------------------------------------------------------------------
  // apb answer: one wait state, read data registered
  // ----------------------------------------------------------------------
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    if (hit(PADDR, cflb_pkg::CFLB_IDX_IN_ONE)) begin
      rdata = in_one_ff;
    end else if (hit(PADDR, cflb_pkg::CFLB_IDX_IN_TWO)) begin
      rdata = in_two_ff;
    end else if (hit(PADDR, cflb_pkg::CFLB_IDX_OUT_ONE)) begin
      // reserved bits 1..0 read zero
      rdata = {out_one_ff, MASK_OUT.converter_one_overload_mask,
               MASK_OUT.converter_two_overload_mask, 2'b00};
    end else if (hit(PADDR, cflb_pkg::CFLB_IDX_OUT_TWO)) begin
      rdata = {out_two_ff, 2'b00, MASK_OUT.regulator_short_mask, reg_short_ff};
    end else if (hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_STAT)) begin
      rdata = {4'h0, irq_stat_ff};
    end else if (hit(PADDR, cflb_pkg::CFLB_IDX_IRQ_MASK)) begin
      rdata = {4'h0, irq_mask_ff};
    end
  end

  always_ff @(posedge SYS_CLK or negedge ARST_N) begin
    if (!ARST_N) begin
      PREADY <= 1'b0;
      PRDATA <= 32'h0000_0000;
      PSLVERR <= 1'b0;
    end else begin
      PREADY <= PSEL && PENABLE && !PREADY;
      PSLVERR <= PSEL && PENABLE && !PREADY && !mapped;
      PRDATA <= (PSEL && PENABLE && !PREADY && !PWRITE) ? {24'h00_0000, rdata} : 32'h0000_0000;
    end
  end

endmodule

/* File: inc/cflb_pkg.sv */
// package for the channel fault latch bank: register map, field layout, reset values
// assumes an apb slave with 32-bit data and one word per register
//
// Notes on behaviour
// - input one latch at 0x36, read-only, bits 7..0: open,short,p/n gnd,bias,battery
// - input two latch at 0x37, same bit order and meaning as input one
// - fault flag reads 1 once detected, self clearing, all registers reset to zero
// - output one at 0x38: bits 7..4 p/n short, p/n driver virtual-ground, read-only
// - output one bit 3: read/write converter one overload mask, reset 0
// - output one bit 2: read/write converter two overload mask, reset 0
// - output two at 0x39: bits 7..4 same ordering as output one
// - output two bit 1: read/write regulator short mask, reset 0
// - output two bit 0: read-only self clearing regulator short latch
package cflb_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses: index times four)
  // ----------------------------------------------------------------------
  localparam logic [7:0] CFLB_IDX_IN_ONE = 8'h36;
  localparam logic [7:0] CFLB_IDX_IN_TWO = 8'h37;
  localparam logic [7:0] CFLB_IDX_OUT_ONE = 8'h38;
  localparam logic [7:0] CFLB_IDX_OUT_TWO = 8'h39;
  localparam logic [7:0] CFLB_IDX_IRQ_STAT = 8'h3E;
  localparam logic [7:0] CFLB_IDX_IRQ_MASK = 8'h3F;
  localparam int CFLB_ADDR_W = 10;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int CFLB_CONV_ONE_MASK_BIT = 3;
  localparam int CFLB_CONV_TWO_MASK_BIT = 2;
  localparam int CFLB_REG_SHORT_MASK_BIT = 1;
  localparam int CFLB_REG_SHORT_LATCH_BIT = 0;
  localparam logic [7:0] CFLB_LATCH_RST = 8'h00;
  localparam logic [7:0] CFLB_OUT_ONE_WMASK = 8'h0C;
  localparam logic [7:0] CFLB_OUT_TWO_WMASK = 8'h02;
  localparam logic [7:0] CFLB_OUT_FAULT_MASK = 8'hF0;
  localparam logic [3:0] CFLB_IRQ_RST = 4'h0;
  localparam int CFLB_IRQ_W = 4;

  // one level detector output per fault flag
  typedef struct packed {
    logic [7:0] in_one;
    logic [7:0] in_two;
    logic [3:0] out_one;
    logic [3:0] out_two;
    logic regulator_short;
  } cflb_fault_t;

  typedef struct packed {
    logic converter_one_overload_mask;
    logic converter_two_overload_mask;
    logic regulator_short_mask;
  } cflb_mask_t;

endpackage
